// File: common/tape_ctl_defs.svh
// Purpose: constants for the tape controller function decoder
// Assumes: 16-bit accumulator words, two-bit director field
// Notes: included by bare name
`ifndef TAPE_CTL_DEFS_SVH
`define TAPE_CTL_DEFS_SVH
`define DIR_WRITE 2'h0
`define DIR_CTRL 2'h1
`define DIR_USEL 2'h2
`define DIR_BUF 2'h3
`define CF_CLR_CTL 0
`define CF_CLR_INT 1
`define CF_IE_DATA 2
`define CF_IE_EOP 3
`define CF_IE_ALARM 4
`define MOT_HI 10
`define MOT_LO 7
`define MOT_NONE 4'h0
`define MOT_WRITE 4'h1
`define MOT_READ 4'h2
`define MOT_BKSP 4'h3
`define MOT_WFM 4'h5
`define MOT_SFF 4'h6
`define MOT_SFB 4'h7
`define MOT_REW 4'h8
`define MOT_RUNL 4'hC
`define US_CHAR 0
`define US_EVEN 1
`define US_D800 3
`define US_D556 4
`define US_D1600 5
`define US_ASM 6
`define US_UNIT_HI 9
`define US_UNIT_LO 7
`define US_SEL 10
`define US_DESEL 11
`define US_LOWTH 12
`define UNIT_MAX 3'h3
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

// File: common/tape_ctl_pkg.sv
// Purpose: shared types for the tape controller function decoder
// Assumes: none
// Notes: constants live in tape_ctl_defs.svh
package tape_ctl_pkg;
  typedef struct packed {
    logic [1:0] director;
    logic [15:0] data;
  } host_word_t;
  typedef struct packed {
    logic [2:0] unit;
    logic unit_valid;
    logic char_fmt;
    logic even_par;
    logic assembly;
    logic [2:0] density;
    logic low_thresh;
  } unit_cfg_t;
  typedef struct packed {
    logic [3:0] code;
    logic fwd;
    logic wr;
  } motion_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11,
    ST_LOCK = 2'b10
  } mot_state_t;
endpackage

// File: hdl/tape_ctl.sv
// Purpose: function decoder and motion sequencer for a tape controller
// Assumes: host words arrive as one-cycle strobes; transport status is synchronous
// Notes: read data path and status word assembly live outside this block
`timescale 1ns/10ps
`include "tape_ctl_defs.svh"

// ****************************************
// fifo
// ****************************************
module tape_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `FIFO_DEPTH,
  parameter int AW = `FIFO_AW
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic flush_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp;
  logic [AW:0] rp;
  wire full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire empty = (wp == rp);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rp[AW-1:0]];
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp <= '0;
      rp <= '0;
    end else if (flush_i) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (push) mem[wp[AW-1:0]] <= in_data_i;
  end
endmodule

// Operation
// - director 00 write, 01 control, 10 unit select, 11 buffered start
// - zero motion code rejected only on protect fault
// - nonzero motion rejected if not ready, no done, illegal, busy, fault, protected write; code takes it without done when idle
// - after done, same motion and transfer direction is accepted
// - clears first, then interrupt enables, then motion
// - new motion clears done, alarm and all alarm causes
// - bit 0 clears controller, keeping unit, mode, parity, format
// - bit 1 clears interrupts and enables; same-word enables survive
// - data and done interrupt enables, cleared by clears; reply clears data response
// - bit 4 enables alarm interrupt on listed alarm conditions
// - write motion raises data status or starts buffered output; ends at record end
// - direct write without data locks out, drops forward, no done
// - read motion; late request sets lost data; file mark sets flag
// - backspace one record; at load point accepted without motion
// - write file mark advances, writes mark, normal end sequence
// - search forward/backward to file mark; backward stops at load point
// - rewind stays ready and busy; rewind unload goes not ready
// - unit select rejected when active, fault, illegal or mismatched; accepted clears
// - bit 10 plus unit 0..3 selects; bit 11 deselects alone; master clear deselects
// - character, assembly and even parity bits; odd parity default
// - low threshold reverts on any done or master clear; clear bit keeps it
// - buffered start takes first address minus one, fetches last address plus one
module tape_ctl (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // host output word
  input wire logic out_strobe_i,
  input wire tape_ctl_pkg::host_word_t host_word_i,
  output logic reply_o,
  output logic reject_o,
  // transport status
  input wire logic ready_i,
  input wire logic protected_i,
  input wire logic write_enable_i,
  input wire logic protect_fault_i,
  input wire logic load_point_i,
  input wire logic end_of_record_i,
  input wire logic file_mark_i,
  input wire logic gap_passed_i,
  input wire logic end_of_tape_i,
  input wire logic parity_err_i,
  input wire logic storage_parity_i,
  input wire logic id_abort_i,
  input wire logic fmt_lost_i,
  input wire logic fmt_warn_i,
  input wire logic fmt_present_i,
  input wire logic read_frame_i,
  input wire logic read_taken_i,
  // storage channel
  output logic fetch_req_o,
  output logic [15:0] fetch_addr_o,
  input wire logic fetch_ack_i,
  input wire logic [15:0] fetch_data_i,
  output logic [15:0] last_addr_o,
  output logic buffered_o,
  // write data toward the transport
  output logic wr_valid_o,
  input wire logic wr_ready_i,
  output logic [15:0] wr_data_o,
  // transport control
  output tape_ctl_pkg::unit_cfg_t cfg_o,
  output tape_ctl_pkg::motion_t motion_o,
  output logic forward_o,
  output logic unload_o,
  // status
  output logic busy_o,
  output logic active_o,
  output logic done_o,
  output logic data_status_o,
  output logic alarm_o,
  output logic lost_data_o,
  output logic file_mark_o,
  output logic interrupt_o
);
  tape_ctl_pkg::mot_state_t state;
  tape_ctl_pkg::mot_state_t next_state;
  tape_ctl_pkg::unit_cfg_t cfg;
  tape_ctl_pkg::motion_t mot;
  logic ie_data, ie_eop, ie_alarm;
  logic done, alarm, lost, fmark, dstat, eot_f, par_f, sp_f, pf_f, id_f, fl_f, fw_f, nr_f;
  logic buf_mode, fetching, first_written;

  // ****************************************
  // decode
  // ****************************************
  wire [15:0] a = host_word_i.data;
  wire is_wr = out_strobe_i && host_word_i.director == `DIR_WRITE;
  wire is_cf = out_strobe_i && host_word_i.director == `DIR_CTRL;
  wire is_us = out_strobe_i && host_word_i.director == `DIR_USEL;
  wire is_bf = out_strobe_i && host_word_i.director == `DIR_BUF;
  wire [3:0] code = a[`MOT_HI:`MOT_LO];
  wire legal = code == `MOT_WRITE || code == `MOT_READ || code == `MOT_BKSP ||
               code == `MOT_WFM || code == `MOT_SFF || code == `MOT_SFB ||
               code == `MOT_REW || code == `MOT_RUNL;
  wire new_fwd = !(code == `MOT_BKSP || code == `MOT_SFB || code == `MOT_REW ||
                   code == `MOT_RUNL);
  wire new_wr = code == `MOT_WRITE || code == `MOT_WFM;
  wire compat = done && state == tape_ctl_pkg::ST_DONE && new_fwd == mot.fwd && new_wr == mot.wr;
  wire busy_now = state == tape_ctl_pkg::ST_RUN;
  // a cleared, idle controller may start motion without a prior done
  wire idle_now = state == tape_ctl_pkg::ST_IDLE;
  wire mot_rej = !ready_i || !(done || idle_now) || !legal || (busy_now && !compat) ||
                 protect_fault_i || (new_wr && !write_enable_i);
  wire cf_rej = (code == `MOT_NONE) ? protect_fault_i : mot_rej;
  wire cf_ok = is_cf && !cf_rej;
  wire start = cf_ok && code != `MOT_NONE;
  wire [2:0] dens = a[`US_D1600:`US_D800];
  wire dens_bad = (dens[0] + dens[1] + dens[2]) > 2'd1;
  wire desel_bad = a[`US_DESEL] && (a & ~(16'h0001 << `US_DESEL)) != 16'h0000;
  wire us_mismatch = (a[`US_D1600] && !fmt_present_i) ||
                     (a[`US_SEL] && a[`US_UNIT_HI:`US_UNIT_LO] > `UNIT_MAX);
  wire us_rej = busy_now || protect_fault_i || dens_bad || desel_bad || us_mismatch;
  wire us_ok = is_us && !us_rej;
  wire bf_rej = (!done && busy_now) || !ready_i || protect_fault_i;
  wire wr_rej = !ready_i || !(mot.code == `MOT_WRITE && busy_now) || !dstat ||
                buf_mode || protect_fault_i;
  // controller clear, also on accepted unit select
  wire clr_ctl = (cf_ok && a[`CF_CLR_CTL]) || us_ok;
  wire clr_int = cf_ok && a[`CF_CLR_INT];
  wire end_op = busy_now && ((mot.wr && end_of_record_i && mot.code == `MOT_WRITE) ||
                (mot.code == `MOT_READ && end_of_record_i) ||
                (mot.code == `MOT_BKSP && (end_of_record_i || load_point_i)) ||
                (mot.code == `MOT_WFM && end_of_record_i) ||
                (mot.code == `MOT_SFF && file_mark_i) ||
                (mot.code == `MOT_SFB && (file_mark_i || load_point_i)) ||
                (mot.code == `MOT_REW && load_point_i));
  // no first word when the gap has passed
  wire lockout = busy_now && mot.code == `MOT_WRITE && !buf_mode && gap_passed_i &&
                 !first_written;
  wire alarm_ev = end_of_tape_i || parity_err_i || (read_frame_i && dstat) || file_mark_i ||
                  (busy_now && !ready_i) || storage_parity_i || protect_fault_i ||
                  id_abort_i || fmt_lost_i || fmt_warn_i;
  wire fifo_in_ready;
  wire fifo_push = is_wr && !wr_rej;
  // queue room raises data status again
  wire wr_room = mot.code == `MOT_WRITE && !buf_mode && fifo_in_ready;

  // ****************************************
  // motion sequencer
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      tape_ctl_pkg::ST_IDLE: if (start) next_state = tape_ctl_pkg::ST_RUN;
      tape_ctl_pkg::ST_RUN: begin
        // backspace at load point ends at once
        if (lockout) next_state = tape_ctl_pkg::ST_LOCK;
        else if (end_op) next_state = tape_ctl_pkg::ST_DONE;
      end
      tape_ctl_pkg::ST_DONE: if (start) next_state = tape_ctl_pkg::ST_RUN;
      tape_ctl_pkg::ST_LOCK: if (us_ok) next_state = tape_ctl_pkg::ST_IDLE;
    endcase
    // clear precedes motion in same word
    if (clr_ctl && !start) next_state = tape_ctl_pkg::ST_IDLE;
    else if (clr_ctl && start) next_state = tape_ctl_pkg::ST_RUN;
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= tape_ctl_pkg::ST_IDLE;
      mot <= '0;
      first_written <= 1'b0;
    end else begin
      state <= next_state;
      if (start) mot <= '{code: code, fwd: new_fwd, wr: new_wr};
      if (start) first_written <= 1'b0;
      else if (fifo_push) first_written <= 1'b1;
    end
  end

  // ****************************************
  // unit configuration
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // reset density 800, odd parity, character format
      cfg <= '{unit: 3'h0, unit_valid: 1'b0, char_fmt: 1'b1, even_par: 1'b0,
               assembly: 1'b0, density: 3'b001, low_thresh: 1'b0};
    end else if (us_ok) begin
      if (a[`US_SEL]) begin
        cfg.unit <= a[`US_UNIT_HI:`US_UNIT_LO];
        cfg.unit_valid <= 1'b1;
      end
      if (a[`US_DESEL]) cfg.unit_valid <= 1'b0;
      if (!a[`US_DESEL]) begin
        cfg.char_fmt <= a[`US_CHAR];
        cfg.assembly <= a[`US_ASM];
        cfg.even_par <= a[`US_EVEN];
        cfg.low_thresh <= a[`US_LOWTH];
      end
      if (dens != 3'b000) cfg.density <= dens;
    end else if (end_op) begin
      cfg.low_thresh <= 1'b0;
    end
  end

  // ****************************************
  // flags and interrupts
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {done, alarm, lost, fmark, dstat} <= '0;
      {eot_f, par_f, sp_f, pf_f, id_f, fl_f, fw_f, nr_f} <= '0;
      {ie_data, ie_eop, ie_alarm} <= '0;
    end else begin
      if (clr_ctl || clr_int) {ie_data, ie_eop, ie_alarm} <= '0;
      if (cf_ok && a[`CF_IE_DATA]) ie_data <= 1'b1;
      if (cf_ok && a[`CF_IE_EOP]) ie_eop <= 1'b1;
      if (cf_ok && a[`CF_IE_ALARM]) ie_alarm <= 1'b1;
      // new motion clears done and alarm causes
      if (start || clr_ctl) begin
        {done, alarm, lost, fmark} <= '0;
        {eot_f, par_f, sp_f, pf_f, id_f, fl_f, fw_f, nr_f} <= '0;
      end
      // direct write or read raises data status
      dstat <= (start && !buf_mode && (code == `MOT_WRITE || code == `MOT_READ)) ? 1'b1 :
               (fifo_push || clr_ctl || lost || end_op) ? 1'b0 :
               (busy_now && ((mot.code == `MOT_READ && read_frame_i) || wr_room)) ? 1'b1 :
               dstat;
      if (end_op) done <= 1'b1;
      if (busy_now && mot.code == `MOT_READ && read_frame_i && dstat && !read_taken_i)
        lost <= 1'b1;
      if (busy_now && file_mark_i) fmark <= 1'b1;
      if (end_of_tape_i) eot_f <= 1'b1;
      if (parity_err_i) par_f <= 1'b1;
      if (storage_parity_i) sp_f <= 1'b1;
      if (protect_fault_i) pf_f <= 1'b1;
      if (id_abort_i) id_f <= 1'b1;
      if (fmt_lost_i) fl_f <= 1'b1;
      if (fmt_warn_i) fw_f <= 1'b1;
      if (busy_now && !ready_i) nr_f <= 1'b1;
      if (busy_now && alarm_ev) alarm <= 1'b1;
    end
  end

  // ****************************************
  // buffered transfer start
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      buf_mode <= 1'b0;
      fetching <= 1'b0;
      fetch_addr_o <= 16'h0000;
      last_addr_o <= 16'h0000;
    end else begin
      // latch first address minus one, fetch bound
      if (is_bf && !bf_rej) begin
        buf_mode <= 1'b1;
        fetching <= 1'b1;
        fetch_addr_o <= a;
      end else if (fetching && fetch_ack_i) begin
        fetching <= 1'b0;
        last_addr_o <= fetch_data_i;
      end
      if (clr_ctl || end_op) buf_mode <= 1'b0;
    end
  end

  // direct write words queue toward the transport
  tape_fifo #(.WIDTH(16), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) wr_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .flush_i(clr_ctl),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(a),
    .out_valid_o(wr_valid_o),
    .out_ready_i(wr_ready_i),
    .out_data_o(wr_data_o)
  );

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reply_o <= 1'b0;
      reject_o <= 1'b0;
      forward_o <= 1'b0;
      unload_o <= 1'b0;
      interrupt_o <= 1'b0;
    end else begin
      // full queue refuses a write word
      reply_o <= (cf_ok || us_ok || (is_bf && !bf_rej) || (fifo_push && fifo_in_ready));
      reject_o <= (is_cf && cf_rej) || (is_us && us_rej) || (is_bf && bf_rej) ||
                  (is_wr && (wr_rej || !fifo_in_ready));
      forward_o <= (next_state == tape_ctl_pkg::ST_RUN) && (start ? new_fwd : mot.fwd);
      unload_o <= start && code == `MOT_RUNL;
      interrupt_o <= (ie_data && dstat) || (ie_eop && done) || (ie_alarm && alarm);
    end
  end

  assign busy_o = state == tape_ctl_pkg::ST_RUN;
  assign active_o = busy_o;
  assign done_o = done;
  assign data_status_o = dstat;
  assign alarm_o = alarm;
  assign lost_data_o = lost;
  assign file_mark_o = fmark;
  assign buffered_o = buf_mode;
  assign fetch_req_o = fetching;
  assign cfg_o = cfg;
  assign motion_o = mot;
endmodule

// File: verif/tape_ctl_monitor.sv
// Purpose: port checks for the tape controller decoder
// Assumes: one answer one cycle after each host word
// Notes: bound to tape_ctl below
`timescale 1ns/10ps
`include "tape_ctl_defs.svh"
module tape_ctl_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // host side
  input wire logic out_strobe_i,
  input wire tape_ctl_pkg::host_word_t host_word_i,
  input wire logic reply_o,
  input wire logic reject_o,
  // transport and status
  input wire logic ready_i,
  input wire logic write_enable_i,
  input wire logic protect_fault_i,
  input wire logic active_o,
  input wire logic alarm_o,
  input wire logic lost_data_o,
  input wire logic fetch_req_o,
  input wire logic [15:0] fetch_addr_o,
  input wire tape_ctl_pkg::unit_cfg_t cfg_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire [1:0] dir = host_word_i.director;
  wire [3:0] code = host_word_i.data[`MOT_HI:`MOT_LO];
  wire ctl = out_strobe_i && dir == `DIR_CTRL;
  wire sel = out_strobe_i && dir == `DIR_USEL;
  wire bad = code inside {4'h4, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
  a_one_answer: assert property (out_strobe_i |=> reply_o != reject_o)
    else $error("host word without a single answer");
  a_answer_caused: assert property ((reply_o || reject_o) |-> $past(out_strobe_i))
    else $error("answer without a host word");
  a_idle_kept: assert property (ctl && code == 4'h0 && !protect_fault_i |=> reply_o)
    else $error("idle control word refused");
  a_fault_refused: assert property ((ctl || sel) && protect_fault_i |=> reject_o)
    else $error("word taken during protect fault");
  a_code_refused: assert property (ctl && bad |=> reject_o)
    else $error("illegal motion code taken");
  a_ready_needed: assert property (ctl && code != 4'h0 && !ready_i |=> reject_o)
    else $error("motion taken while not ready");
  a_ring_needed: assert property (ctl && code inside {4'h1, 4'h5} && !write_enable_i
    |=> reject_o)
    else $error("write motion taken without ring");
  a_flags_cleared: assert property (ctl && code != 4'h0 ##1 reply_o
    |-> !alarm_o && !lost_data_o)
    else $error("alarm left standing by new motion");
  a_unit_active: assert property (sel && active_o |=> reject_o)
    else $error("unit select taken while active");
  a_unit_loaded: assert property (sel && host_word_i.data[`US_SEL] ##1 reply_o
    |-> cfg_o.unit_valid && cfg_o.unit == $past(host_word_i.data[9:7]))
    else $error("selected unit not loaded");
  a_cfg_follows: assert property (sel && host_word_i.data[`US_SEL] ##1 reply_o
    |-> cfg_o.low_thresh == $past(host_word_i.data[12])
    && cfg_o.even_par == $past(host_word_i.data[1]))
    else $error("threshold or parity not loaded");
  a_fetch_start: assert property (out_strobe_i && dir == `DIR_BUF ##1 reply_o
    |-> fetch_req_o && fetch_addr_o == $past(host_word_i.data))
    else $error("buffered start without fetch");
  c_motion: cover property (ctl && code != 4'h0 ##1 reply_o);
  c_refused: cover property (ctl ##1 reject_o);
  c_unit: cover property (sel ##1 reply_o);
endmodule
bind tape_ctl tape_ctl_monitor i_tape_ctl_monitor (.clk_sys_i, .reset_n_i, .out_strobe_i,
  .host_word_i, .reply_o, .reject_o, .ready_i, .write_enable_i, .protect_fault_i, .active_o,
  .alarm_o, .lost_data_o, .fetch_req_o, .fetch_addr_o, .cfg_o);

// File: verif/tape_ctl_tb_top.sv
// Purpose: random and corner stimulus for the tape controller decoder
// Assumes: unit 0 present and ready unless driven otherwise
// Notes: seed fixed at 23
`timescale 1ns/10ps
`include "tape_ctl_defs.svh"
module tape_ctl_tb_top;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic out_strobe_i, reply_o, reject_o, fetch_req_o, buffered_o, wr_valid_o;
  tape_ctl_pkg::host_word_t host_word_i;
  logic ready_i = 1'b1, write_enable_i = 1'b1, protect_fault_i = 1'b0, fmt_present_i = 1'b1;
  logic [12:0] ev = '0;
  logic fetch_ack_i = 1'b0, wr_ready_i = 1'b0;
  logic [15:0] fetch_data_i = '0, fetch_addr_o, last_addr_o, wr_data_o;
  tape_ctl_pkg::unit_cfg_t cfg_o;
  tape_ctl_pkg::motion_t motion_o;
  logic forward_o, unload_o, busy_o, active_o, done_o, data_status_o, alarm_o;
  logic lost_data_o, file_mark_o, interrupt_o;
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h0000_0017;
  always #4 clk_sys_i = ~clk_sys_i;
  tape_ctl i_tape_ctl (.clk_sys_i, .reset_n_i, .out_strobe_i, .host_word_i, .reply_o,
    .reject_o, .ready_i, .protected_i(ev[0]), .write_enable_i, .protect_fault_i,
    .load_point_i(ev[1]), .end_of_record_i(ev[2]), .file_mark_i(ev[3]),
    .gap_passed_i(ev[4]), .end_of_tape_i(ev[5]), .parity_err_i(ev[6]),
    .storage_parity_i(ev[7]), .id_abort_i(ev[8]), .fmt_lost_i(ev[9]), .fmt_warn_i(ev[10]),
    .fmt_present_i, .read_frame_i(ev[11]), .read_taken_i(ev[12]), .fetch_req_o,
    .fetch_addr_o, .fetch_ack_i, .fetch_data_i, .last_addr_o, .buffered_o, .wr_valid_o,
    .wr_ready_i, .wr_data_o, .cfg_o, .motion_o, .forward_o, .unload_o, .busy_o, .active_o,
    .done_o, .data_status_o, .alarm_o, .lost_data_o, .file_mark_o, .interrupt_o);
  tape_host_model i_tape_host_model (.clk_sys_i, .out_strobe_o(out_strobe_i),
    .host_word_o(host_word_i), .reply_i(reply_o), .reject_i(reject_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic ctl_rej(input logic [3:0] c, input logic r, input logic f,
    input logic w);
    return f || (c != 4'h0 && (!r || c inside {4'h4, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF}
      || (c inside {4'h1, 4'h5} && !w)));
  endfunction
  function automatic logic sel_rej(input logic [15:0] a, input logic f, input logic m);
    return f || (a[11] && a != 16'h0800) || (a[10] && a[9:7] > 3'h3)
      || $countones(a[5:3]) > 1 || (a[5] && !m);
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic put(input logic [1:0] d, input logic [15:0] a, input logic exp);
    logic acc, one;
    i_tape_host_model.send(d, a, acc, one);
    check("single answer", 1'b1, one);
    check("accept", exp, acc);
  endtask
  initial begin
    logic [15:0] a, w0;
    logic [15:0] corner [4] = '{16'h0600, 16'h0801, 16'h0800, 16'h0418};
    int n, k;
    repeat (5) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    put(`DIR_USEL, 16'h0408, 1'b1);
    check("density", 3'h1, cfg_o.density);
    for (int i = 0; i < 30; i++) begin
      protect_fault_i = 1'b0;
      put(`DIR_CTRL, 16'h0001, 1'b1);
      a = (i < 4) ? corner[i] : rnd() & 32'h0000_1ffb;
      protect_fault_i = (i >= 4) && rnd() % 4 == 0;
      fmt_present_i = rnd() % 2;
      put(`DIR_USEL, a, !sel_rej(a, protect_fault_i, fmt_present_i));
      if (!sel_rej(a, protect_fault_i, fmt_present_i) && a[10]) begin
        check("unit", a[9:7], cfg_o.unit);
        check("threshold", a[12], cfg_o.low_thresh);
        check("parity", a[1], cfg_o.even_par);
        if ($countones(a[5:3]) == 1) check("density", a[5:3], cfg_o.density);
      end
    end
    protect_fault_i = 1'b0;
    put(`DIR_USEL, 16'h0408, 1'b1);
    for (int i = 0; i < 40; i++) begin
      {ready_i, protect_fault_i, write_enable_i} = 3'h5;
      put(`DIR_CTRL, 16'h0001, 1'b1);
      a = (i < 16) ? {5'h00, 4'(i), 7'h00} : {5'h00, 4'(rnd()), 2'h0, 4'(rnd()), 1'b0};
      {ready_i, protect_fault_i, write_enable_i} = (i < 16) ? 3'h5 : 3'(rnd());
      ev = (i < 16) ? '0 : 13'(rnd() & rnd() & rnd());
      put(`DIR_CTRL, a, !ctl_rej(a[10:7], ready_i, protect_fault_i, write_enable_i));
      if (i == 12) check("unload", 1'b1, unload_o);
      ev = '0;
    end
    {ready_i, protect_fault_i, write_enable_i} = 3'h5;
    put(`DIR_CTRL, 16'h0001, 1'b1);
    check("busy after clear", 1'b0, busy_o);
    check("unit kept", 3'h0, cfg_o.unit);
    put(`DIR_CTRL, 16'h0100, 1'b1);
    check("busy", 1'b1, busy_o);
    check("forward", 1'b1, forward_o);
    put(`DIR_CTRL, 16'h0400, 1'b0);
    put(`DIR_CTRL, 16'h0001, 1'b1);
    put(`DIR_CTRL, 16'h0080, 1'b1);
    check("data status", 1'b1, data_status_o);
    w0 = rnd();
    n = 0;
    for (int i = 0; i < 20; i++) begin
      logic acc, one;
      i_tape_host_model.send(`DIR_WRITE, (i == 0) ? w0 : 16'(rnd()), acc, one);
      if (acc && n == i) n++;
    end
    check("words buffered", 16, n);
    n = 0;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_sys_i);
      if (wr_valid_o && wr_ready_i) begin
        if (n == 0) check("first word", w0, wr_data_o);
        n++;
      end
      wr_ready_i <= rnd() % 2;
    end
    check("words drained", 16, n);
    put(`DIR_CTRL, 16'h0001, 1'b1);
    put(`DIR_CTRL, 16'h0308, 1'b1);
    check("motion", 4'h6, motion_o.code);
    check("search forward", 1'b1, forward_o);
    @(posedge clk_sys_i);
    ev[3] <= 1'b1;
    @(posedge clk_sys_i);
    ev <= '0;
    #1;
    check("done", 1'b1, done_o);
    check("file mark", 1'b1, file_mark_o);
    check("alarm", 1'b1, alarm_o);
    put(`DIR_CTRL, 16'h0300, 1'b1);
    check("interrupt", 1'b1, interrupt_o);
    put(`DIR_CTRL, 16'h0001, 1'b1);
    put(`DIR_BUF, 16'h1234, 1'b1);
    check("fetch address", 16'h1234, fetch_addr_o);
    fetch_data_i <= 16'h4321;
    fetch_ack_i <= 1'b1;
    @(posedge clk_sys_i);
    fetch_ack_i <= 1'b0;
    #1;
    for (k = 0; k < 10 && buffered_o !== 1'b1; k++) @(posedge clk_sys_i);
    check("buffered", 1'b1, buffered_o);
    check("last address", 16'h4321, last_addr_o);
    close_out();
  end
endmodule

// File: verif/tape_host_model.sv
// Purpose: host processor issuing output words
// Assumes: answer registered at the edge taking the word
// Notes: released word shows its inverse
`timescale 1ns/10ps
module tape_host_model (
  // clock
  input wire logic clk_sys_i,
  // output word
  output logic out_strobe_o,
  output tape_ctl_pkg::host_word_t host_word_o,
  input wire logic reply_i,
  input wire logic reject_i
);
  initial begin
    out_strobe_o = 1'b0;
    host_word_o = '0;
  end
  // director and data together, one idle cycle before next word
  task automatic send(input logic [1:0] d, input logic [15:0] a, output logic acc,
    output logic one);
    @(posedge clk_sys_i);
    out_strobe_o <= 1'b1;
    host_word_o <= {d, a};
    @(posedge clk_sys_i);
    out_strobe_o <= 1'b0;
    // stale word would hide a late sample
    host_word_o <= ~{d, a};
    #1;
    acc = reply_i;
    one = reply_i ^ reject_i;
  endtask
endmodule
